// File: verilog/sad_system_address_decoder.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sad_system_address_decoder (
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // processor access to classify
   input wire logic dec_req,
   input wire logic [35:0] dec_addr,
   input wire logic dec_write,
   input wire logic dec_io,
   input wire logic dec_smm,
   input wire logic [1:0] dec_origin,
   // decode result
   output logic dec_valid,
   output logic [1:0] dec_dest,
   output logic dec_discard,
   output logic [63:0] dec_zero_rdata
);

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic ph_wr_r;
   logic ph_rd_r;
   logic [7:0] ph_addr_r;
   logic [25:0] seg_attr_r;
   logic [3:0] legacy_r;
   logic [11:0] top_r;
   logic last_valid_r;
   logic [1:0] last_dest_r;
   logic last_discard_r;
   logic [35:0] last_addr_r;
   logic [15:0] cnt_r [4];
   logic take;

   // hsize is ignored: only whole-word transfers exist on this bus
   assign take = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_r <= 1'b0;
         ph_rd_r <= 1'b0;
         ph_addr_r <= 8'h00;
      end else if (hready) begin
         ph_wr_r <= take & hwrite;
         ph_rd_r <= take & ~hwrite;
         ph_addr_r <= haddr[7:0];
      end
   end

   // settings change only between decodes, so a decode sees one whole set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seg_attr_r <= sad_pkg::SAD_SEG_ATTR_RST;
         legacy_r <= sad_pkg::SAD_LEGACY_RST;
         top_r <= sad_pkg::SAD_TOP_RST;
      end else if (ph_wr_r) begin
         unique case (ph_addr_r)
            sad_pkg::SAD_OFS_SEG_ATTR: seg_attr_r <= hwdata[25:0];
            sad_pkg::SAD_OFS_LEGACY: legacy_r <= hwdata[3:0];
            sad_pkg::SAD_OFS_TOP:
               top_r <= hwdata[sad_pkg::SAD_TOP_LSB +: 12];
            default: ;
         endcase
      end
   end

   // read mux of flip-flop contents; unmapped words read as zero
   always_comb begin
      hrdata = 32'h00000000;
      if (ph_rd_r) begin
         case (ph_addr_r)
            sad_pkg::SAD_OFS_SEG_ATTR: hrdata = {6'h00, seg_attr_r};
            sad_pkg::SAD_OFS_LEGACY: hrdata = {28'h0000000, legacy_r};
            sad_pkg::SAD_OFS_TOP: hrdata = {top_r, 20'h00000};
            sad_pkg::SAD_OFS_LAST:
               hrdata = {28'h0000000, last_discard_r, last_valid_r,
                         last_dest_r};
            sad_pkg::SAD_OFS_LAST_ADDR: hrdata = last_addr_r[31:0];
            sad_pkg::SAD_OFS_CNT_BASE:
               hrdata = {16'h0000, cnt_r[0]};
            sad_pkg::SAD_OFS_CNT_BASE + 8'h04:
               hrdata = {16'h0000, cnt_r[1]};
            sad_pkg::SAD_OFS_CNT_BASE + 8'h08:
               hrdata = {16'h0000, cnt_r[2]};
            sad_pkg::SAD_OFS_CNT_BASE + 8'h0C:
               hrdata = {16'h0000, cnt_r[3]};
            default: hrdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // address classification
   // ----------------------------------------
   logic [31:0] a;
   logic above_4g;
   logic vga_steer;
   logic mono_present;
   logic smm_compat;
   logic hole_en;
   logic [3:0] seg_idx;
   logic seg_en;
   logic in_mono_mem;
   logic in_mono_io;
   sad_pkg::sad_dest_t vga_dest;
   sad_pkg::sad_dest_t dest_nxt;

   assign a = dec_addr[31:0];
   assign above_4g = |dec_addr[35:32];
   assign vga_steer = legacy_r[sad_pkg::SAD_LEG_VGA_STEER];
   assign mono_present = legacy_r[sad_pkg::SAD_LEG_MONO_PRESENT];
   assign smm_compat = legacy_r[sad_pkg::SAD_LEG_SMM_COMPAT];
   assign hole_en = legacy_r[sad_pkg::SAD_LEG_FIXED_HOLE];

   // segments 0..11 are 16 KB each from C0000; segment 12 is the 64 KB bios
   assign seg_idx = (a >= sad_pkg::SAD_BIOS_BASE) ? 4'hC :
      4'((a - sad_pkg::SAD_SEG_BASE) >> sad_pkg::SAD_SEG_SHIFT);
   assign seg_en = dec_write ? seg_attr_r[{seg_idx, 1'b1}]
                             : seg_attr_r[{seg_idx, 1'b0}];

   assign in_mono_mem = (a >= sad_pkg::SAD_MONO_BASE) &&
                        (a < sad_pkg::SAD_MONO_END);
   assign in_mono_io = (a[15:0] == sad_pkg::SAD_IO_MONO_0) ||
                       (a[15:0] == sad_pkg::SAD_IO_MONO_1) ||
                       (a[15:0] == sad_pkg::SAD_IO_MONO_2) ||
                       (a[15:0] == sad_pkg::SAD_IO_MONO_3) ||
                       (a[15:0] == sad_pkg::SAD_IO_MONO_4) ||
                       (a[15:0] == sad_pkg::SAD_IO_MONO_5);

   // graphics bridge claims first; a present mono adapter pulls its
   // range back to the hub link
   always_comb begin
      vga_dest = sad_pkg::SAD_DEST_HUB;
      if (vga_steer) begin
         vga_dest = sad_pkg::SAD_DEST_GFX;
         if (mono_present && in_mono_mem) begin
            vga_dest = sad_pkg::SAD_DEST_HUB;
         end
      end
   end

   // one destination out of one priority chain
   always_comb begin
      dest_nxt = sad_pkg::SAD_DEST_HUB;
      if (dec_io) begin
         if (in_mono_io && vga_steer && !mono_present) begin
            dest_nxt = sad_pkg::SAD_DEST_GFX;
         end else begin
            dest_nxt = sad_pkg::SAD_DEST_HUB;
         end
      end else if (above_4g) begin
         dest_nxt = sad_pkg::SAD_DEST_TERM;
      end else if (a < sad_pkg::SAD_DOS_END) begin
         dest_nxt = sad_pkg::SAD_DEST_DRAM;
      end else if (a < sad_pkg::SAD_VGA_END) begin
         if (smm_compat && dec_smm &&
             dec_origin == sad_pkg::SAD_ORG_CPU) begin
            dest_nxt = sad_pkg::SAD_DEST_DRAM;
         end else begin
            dest_nxt = vga_dest;
         end
      end else if (a < sad_pkg::SAD_ONE_MB) begin
         // a disabled segment falls to the hub; its dram stays hidden
         dest_nxt = seg_en ? sad_pkg::SAD_DEST_DRAM
                           : sad_pkg::SAD_DEST_HUB;
      end else if (a >= sad_pkg::SAD_HIGH_BIOS) begin
         dest_nxt = sad_pkg::SAD_DEST_HUB;
      end else if (a[31:20] < top_r) begin
         if (hole_en && a[31:20] == sad_pkg::SAD_HOLE_MB) begin
            dest_nxt = sad_pkg::SAD_DEST_HUB;
         end else begin
            dest_nxt = sad_pkg::SAD_DEST_DRAM;
         end
      end else begin
         // no graphics window decode here, so all of it is pci side
         dest_nxt = sad_pkg::SAD_DEST_HUB;
      end
   end

   // ----------------------------------------
   // result registers
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec_valid <= 1'b0;
         dec_dest <= sad_pkg::SAD_DEST_HUB;
         dec_discard <= 1'b0;
      end else begin
         dec_valid <= dec_req;
         if (dec_req) begin
            dec_dest <= dest_nxt;
            dec_discard <= (dest_nxt == sad_pkg::SAD_DEST_TERM) &&
                           dec_write;
         end
      end
   end

   // zero fill is the only data a terminated read ever gets
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec_zero_rdata <= 64'h0000000000000000;
      end else if (dec_req) begin
         dec_zero_rdata <= 64'h0000000000000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_valid_r <= 1'b0;
         last_dest_r <= sad_pkg::SAD_DEST_HUB;
         last_discard_r <= 1'b0;
         last_addr_r <= 36'h000000000;
      end else if (dec_req) begin
         last_valid_r <= 1'b1;
         last_dest_r <= dest_nxt;
         last_discard_r <= (dest_nxt == sad_pkg::SAD_DEST_TERM) &&
                           dec_write;
         last_addr_r <= dec_addr;
      end
   end

   // per-destination decode counters, wrap at 16 bits
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cnt
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cnt_r[gi] <= 16'h0000;
            end else if (dec_req && dest_nxt == 2'(gi)) begin
               cnt_r[gi] <= cnt_r[gi] + 16'h0001;
            end
         end
      end
   endgenerate

endmodule

// File: verilog/sad_pkg.sv
package sad_pkg;

   // ----------------------------------------
   // destinations
   // ----------------------------------------
   typedef enum logic [1:0] {
      SAD_DEST_DRAM = 2'b00,
      SAD_DEST_HUB  = 2'b01,
      SAD_DEST_GFX  = 2'b10,
      SAD_DEST_TERM = 2'b11
   } sad_dest_t;

   typedef enum logic [1:0] {
      SAD_ORG_CPU = 2'b00,
      SAD_ORG_GFX = 2'b01,
      SAD_ORG_HUB = 2'b10
   } sad_origin_t;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] SAD_OFS_SEG_ATTR = 8'h00;
   localparam logic [7:0] SAD_OFS_LEGACY = 8'h04;
   localparam logic [7:0] SAD_OFS_TOP = 8'h08;
   localparam logic [7:0] SAD_OFS_LAST = 8'h0C;
   localparam logic [7:0] SAD_OFS_LAST_ADDR = 8'h10;
   localparam logic [7:0] SAD_OFS_CNT_BASE = 8'h20;

   // segment attributes: read enable at 2*i, write enable at 2*i+1
   localparam int SAD_NUM_SEG = 13;
   localparam logic [25:0] SAD_SEG_ATTR_RST = 26'h0000000;

   localparam int SAD_LEG_VGA_STEER = 0;
   localparam int SAD_LEG_MONO_PRESENT = 1;
   localparam int SAD_LEG_SMM_COMPAT = 2;
   localparam int SAD_LEG_FIXED_HOLE = 3;
   localparam logic [3:0] SAD_LEGACY_RST = 4'h0;

   // top of main memory in 1 MB units, register bits 31:20
   localparam int SAD_TOP_LSB = 20;
   localparam logic [11:0] SAD_TOP_RST = 12'h000;

   // ----------------------------------------
   // address map
   // ----------------------------------------
   localparam logic [31:0] SAD_DOS_END = 32'h000A0000;
   localparam logic [31:0] SAD_VGA_END = 32'h000C0000;
   localparam logic [31:0] SAD_MONO_BASE = 32'h000B0000;
   localparam logic [31:0] SAD_MONO_END = 32'h000B8000;
   localparam logic [31:0] SAD_SEG_BASE = 32'h000C0000;
   localparam logic [31:0] SAD_BIOS_BASE = 32'h000F0000;
   localparam logic [31:0] SAD_ONE_MB = 32'h00100000;
   localparam logic [11:0] SAD_HOLE_MB = 12'h00F;
   localparam logic [31:0] SAD_HIGH_BIOS = 32'hFFE00000;
   localparam int SAD_SEG_SHIFT = 14;

   localparam logic [15:0] SAD_IO_MONO_0 = 16'h03B4;
   localparam logic [15:0] SAD_IO_MONO_1 = 16'h03B5;
   localparam logic [15:0] SAD_IO_MONO_2 = 16'h03B8;
   localparam logic [15:0] SAD_IO_MONO_3 = 16'h03B9;
   localparam logic [15:0] SAD_IO_MONO_4 = 16'h03BA;
   localparam logic [15:0] SAD_IO_MONO_5 = 16'h03BF;

endpackage

// File: sim/sad_decoder_chk.sv
`timescale 1ns/1ps
module sad_decoder_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic dec_req,
   input wire logic [35:0] dec_addr,
   input wire logic dec_write,
   input wire logic dec_io,
   input wire logic dec_valid,
   input wire logic [1:0] dec_dest,
   input wire logic dec_discard,
   input wire logic [63:0] dec_zero_rdata
);
   // ----------------------------------------
   // decode port checks
   // ----------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire logic mem = dec_req && !dec_io;
   valid_follows_a: assert property (
      dec_req |=> dec_valid) else $error("no valid after request");
   valid_pulse_a: assert property (
      !dec_req |=> !dec_valid) else $error("valid without request");
   result_hold_a: assert property (
      !dec_req |=> $stable(dec_dest) && $stable(dec_discard))
      else $error("result moved between requests");
   above_4g_a: assert property (
      mem && |dec_addr[35:32] |=> dec_dest == sad_pkg::SAD_DEST_TERM)
      else $error("access above 4 GB not terminated");
   discard_only_a: assert property (
      dec_req |=> dec_discard == $past(mem && dec_write && |dec_addr[35:32]))
      else $error("discard flag wrong");
   zero_data_a: assert property (
      dec_zero_rdata == 64'h0) else $error("terminated read data not zero");
   dos_dram_a: assert property (
      mem && dec_addr < 36'h0000A0000 |=> dec_dest == sad_pkg::SAD_DEST_DRAM)
      else $error("low region not sent to dram");
   high_bios_a: assert property (
      mem && dec_addr[35:21] == 15'h07FF |=> dec_dest == sad_pkg::SAD_DEST_HUB)
      else $error("high bios not sent to hub link");
endmodule
bind sad_system_address_decoder sad_decoder_chk sad_decoder_chk_i (
   .hclk(hclk), .hresetn(hresetn), .dec_req(dec_req), .dec_addr(dec_addr),
   .dec_write(dec_write), .dec_io(dec_io), .dec_valid(dec_valid),
   .dec_dest(dec_dest), .dec_discard(dec_discard),
   .dec_zero_rdata(dec_zero_rdata));

// File: sim/sad_cpu_model.sv
`timescale 1ns/1ps
module sad_cpu_model (
   input wire logic hclk,
   output logic dec_req,
   output logic [35:0] dec_addr,
   output logic dec_write,
   output logic dec_io,
   output logic dec_smm,
   output logic [1:0] dec_origin
);
   initial begin
      dec_req = 1'b0;
      dec_addr = 36'h0;
      dec_write = 1'b0;
      dec_io = 1'b0;
      dec_smm = 1'b0;
      dec_origin = 2'b00;
   end
   // k: write, io, smm, origin; callers keep ranges apart, no overlap
   task automatic access(input logic [35:0] a, input logic [4:0] k);
      @(posedge hclk);
      dec_req <= 1'b1;
      dec_addr <= a;
      dec_write <= k[0];
      dec_io <= k[1];
      dec_smm <= k[2];
      dec_origin <= k[4:3];
      @(posedge hclk);
      dec_req <= 1'b0;
      // idle bus must not show a stale address
      dec_addr <= ~a;
   endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dec_valid;
   logic dec_discard, dec_req, dec_write, dec_io, dec_smm;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, dec_dest, dec_origin;
   logic [2:0] hsize;
   logic [35:0] dec_addr;
   logic [63:0] dec_zero_rdata;
   logic [25:0] attr;
   logic [15:0] ports [6] = '{16'h03B4, 16'h03B5, 16'h03B8, 16'h03B9,
      16'h03BA, 16'h03BF};
   int fails, num_checks, cyc;
   sad_system_address_decoder sad_system_address_decoder_i (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dec_req(dec_req), .dec_addr(dec_addr), .dec_write(dec_write),
      .dec_io(dec_io), .dec_smm(dec_smm), .dec_origin(dec_origin),
      .dec_valid(dec_valid), .dec_dest(dec_dest),
      .dec_discard(dec_discard), .dec_zero_rdata(dec_zero_rdata));
   sad_cpu_model sad_cpu_model_i (.hclk(hclk), .dec_req(dec_req),
      .dec_addr(dec_addr), .dec_write(dec_write), .dec_io(dec_io),
      .dec_smm(dec_smm), .dec_origin(dec_origin));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // hangs end here; whole run needs a few hundred cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         wrap_up;
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask
   task automatic dec(input logic [35:0] a, input logic [4:0] k,
         input logic [1:0] exp);
      sad_cpu_model_i.access(a, k);
      #1;
      chk(dec_valid, 1'b1);
      chk(dec_dest, exp);
   endtask
   // expected video window route from steering and mono bits
   function automatic logic [1:0] vid(input logic [3:0] l, input logic m);
      if (!l[0] || (m && l[1])) return sad_pkg::SAD_DEST_HUB;
      return sad_pkg::SAD_DEST_GFX;
   endfunction
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(sad_pkg::SAD_OFS_SEG_ATTR, 32'h00000000);
      rdc(sad_pkg::SAD_OFS_LEGACY, 32'h00000000);
      rdc(8'h40, 32'h00000000);
      dec(36'h000000000, 5'h00, sad_pkg::SAD_DEST_DRAM);
      dec(36'h00009FFFF, 5'h01, sad_pkg::SAD_DEST_DRAM);
      dec(36'h0000F0000, 5'h00, sad_pkg::SAD_DEST_HUB);
      dec(36'h0FFE00000, 5'h00, sad_pkg::SAD_DEST_HUB);
      dec(36'h100000000, 5'h01, sad_pkg::SAD_DEST_TERM);
      chk(dec_discard, 1'b1);
      dec(36'hFFFFFFFF0, 5'h00, sad_pkg::SAD_DEST_TERM);
      chk(dec_discard, 1'b0);
      chk(dec_zero_rdata, 64'h0);
      rdc(sad_pkg::SAD_OFS_LAST, 32'h00000007);
      rdc(sad_pkg::SAD_OFS_LAST_ADDR, 32'hFFFFFFF0);
      for (int i = 0; i < 4; i++)
         rdc(sad_pkg::SAD_OFS_CNT_BASE + 8'(4 * i),
            (i == 2) ? 32'h00000000 : 32'h00000002);
      bus(1'b1, sad_pkg::SAD_OFS_LAST, 32'hFFFFFFFF);
      rdc(sad_pkg::SAD_OFS_LAST, 32'h00000007);
      $display("test defaults done");
      for (int i = 0; i < 13; i++) attr[2*i +: 2] = 2'(i % 4);
      bus(1'b1, sad_pkg::SAD_OFS_SEG_ATTR, {6'h00, attr});
      rdc(sad_pkg::SAD_OFS_SEG_ATTR, {6'h00, attr});
      chk(hresp, 1'b0);
      chk(hreadyout, 1'b1);
      for (int i = 0; i < 13; i++) begin
         dec(36'h0000C0000 + 36'(i * 16384), 5'h00, attr[2*i] ?
            sad_pkg::SAD_DEST_DRAM : sad_pkg::SAD_DEST_HUB);
         dec(36'h0000C3FFF + 36'(i * 16384), 5'h01, attr[2*i+1] ?
            sad_pkg::SAD_DEST_DRAM : sad_pkg::SAD_DEST_HUB);
      end
      $display("test segments done");
      for (int l = 0; l < 8; l++) begin
         bus(1'b1, sad_pkg::SAD_OFS_LEGACY, 32'(l));
         dec(36'h0000A0000, 5'h04, l[2] ? sad_pkg::SAD_DEST_DRAM :
            vid(4'(l), 1'b0));
         dec(36'h0000A0000, 5'h00, vid(4'(l), 1'b0));
         dec(36'h0000BFFFF, 5'h0C, vid(4'(l), 1'b0));
         dec(36'h000B7FFF, 5'h14, vid(4'(l), 1'b1));
         dec(36'h0000B0000, 5'h01, vid(4'(l), 1'b1));
         for (int p = 0; p < 6; p++)
            dec({20'h00000, ports[p]}, 5'h02, vid(4'(l), 1'b1));
         dec(36'h0000003B6, 5'h02, sad_pkg::SAD_DEST_HUB);
      end
      $display("test legacy done");
      bus(1'b1, sad_pkg::SAD_OFS_TOP, 32'h04000000);
      dec(36'h003FFFFFF, 5'h00, sad_pkg::SAD_DEST_DRAM);
      dec(36'h004000000, 5'h00, sad_pkg::SAD_DEST_HUB);
      dec(36'h0FEC00000, 5'h00, sad_pkg::SAD_DEST_HUB);
      dec(36'h000F00000, 5'h01, sad_pkg::SAD_DEST_DRAM);
      bus(1'b1, sad_pkg::SAD_OFS_LEGACY, 32'h00000008);
      dec(36'h000F00000, 5'h01, sad_pkg::SAD_DEST_HUB);
      dec(36'h000FFFFFF, 5'h00, sad_pkg::SAD_DEST_HUB);
      dec(36'h001000000, 5'h00, sad_pkg::SAD_DEST_DRAM);
      $display("test top and hole done");
      wrap_up;
   end
endmodule
